// *** pwr_defines.svh ***
// constants for the sleep and idle power controller
`ifndef PWR_DEFINES_SVH
`define PWR_DEFINES_SVH
// power-save operand encoding
`define PSAVE_OP_SLEEP 1'h0
`define PSAVE_OP_IDLE 1'h1
// oscillator select codes (current_osc_select / osc_config_field)
`define OSC_FRC 3'h0
`define OSC_EC 3'h1
`define OSC_XT 3'h2
`define OSC_XT_PLL 3'h3
`define OSC_LP 3'h4
// source config: on a power-on wake 2'h0 forces fast rc, otherwise primary from config field
`define OSC_SRC_FRC 2'h0
// timing
`define CLK_PERIOD_NS 4
`define POR_DELAY_NS 10000
`define POR_DELAY_CYC ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_DELAY_CYC_DEF 20'd1000
`define POWER_UP_TIMER_DELAY_CYC_DEF 20'd500000
`define TMR_W 20
`endif

// *** pwr_pkg.sv ***
// types for the sleep and idle power controller
package pwr_pkg;
  // controller states, one-hot
  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_IDLE = 6'h02,
    ST_SLEEP = 6'h04,
    ST_WAKE_DLY = 6'h08,
    ST_WAIT_CLK = 6'h10,
    ST_WAKE_DONE = 6'h20
  } pwr_state_t;
  // status flags held for the reset control register
  typedef struct packed {
    logic sleep_flag;
    logic idle_flag;
    logic watchdog_timeout_flag;
  } status_t;
  // wake sources
  typedef struct packed {
    logic irq;
    logic por;
    logic master_clear_pin;
    logic wdt;
  } wake_src_t;
  // clock gating and oscillator controls
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic low_power_rc_oscillator_en;
    logic fail_safe_clock_monitor_active;
  } clk_ctl_t;
  // delay timer state
  typedef struct packed {
    logic [19:0] count;
    logic busy;
  } tmr_state_t;
endpackage

// *** pwr_wake_timer.sv ***
// down counter that times the wake-up delay
`timescale 1ns/1ps
`include "pwr_defines.svh"
module pwr_wake_timer (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [`TMR_W-1:0] value_i,
  output logic done_o
);
  // ==========================
  // state
  pwr_pkg::tmr_state_t r;
  pwr_pkg::tmr_state_t next_r;
  // next state: load or count down
  always_comb begin
    next_r = r;
    if (load_i) begin
      next_r.count = value_i;
      next_r.busy = 1'b1;
    end else if (r.busy) begin
      if (r.count <= `TMR_W'h1) begin
        next_r.busy = 1'b0;
        next_r.count = '0;
      end else begin
        next_r.count = r.count - `TMR_W'h1;
      end
    end
  end
  // register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  // one-cycle pulse when the count expires; kept off load_i so no comb loop forms
  assign done_o = r.busy && (r.count <= `TMR_W'h1);
endmodule

// *** pwr_ctrl.sv ***
// sleep and idle power-saving controller
`timescale 1ns/1ps
`include "pwr_defines.svh"
module pwr_ctrl #(
  parameter logic [`TMR_W-1:0] POWER_UP_TIMER_CYC = `POWER_UP_TIMER_DELAY_CYC_DEF,
  parameter logic [`TMR_W-1:0] LOCK_CYC = `LOCK_DELAY_CYC_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic power_save_instruction_i,
  input wire logic psave_operand_i,
  input wire logic irq_wake_i,
  input wire logic por_i,
  input wire logic master_clear_pin_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_enable_i,
  input wire logic fail_safe_clock_monitor_enable_i,
  input wire logic clk_switch_enable_i,
  input wire logic power_up_timer_enable_i,
  input wire logic [2:0] current_osc_select_i,
  input wire logic [2:0] osc_config_field_i,
  input wire logic [1:0] osc_source_config_i,
  input wire logic lp_run_in_sleep_i,
  input wire logic osc_startup_done_i,
  input wire logic pll_lock_i,
  input wire logic osc_running_i,
  input wire logic [7:0] periph_idle_stop_i,
  input wire logic status_clear_i,
  output logic cpu_clk_en_o,
  output logic [7:0] periph_clk_en_o,
  output logic osc_en_o,
  output logic low_power_rc_oscillator_en_o,
  output logic fail_safe_clock_monitor_active_o,
  output logic [2:0] wake_osc_o,
  output logic clock_fail_trap_o,
  output logic fast_rc_force_o,
  output logic service_irq_o,
  output logic resume_next_o,
  output logic system_reset_o,
  output logic sleep_flag_o,
  output logic idle_flag_o,
  output logic watchdog_timeout_flag_o
);
  // ==========================
  // reset synchroniser
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================
  // state record
  typedef struct packed {
    pwr_pkg::pwr_state_t st;
    pwr_pkg::status_t stat;
    pwr_pkg::clk_ctl_t clk;
    logic [2:0] osc;      // oscillator to restart
    logic irq_pend;       // wake was from an interrupt
    logic trap;
    logic frc_force;
    logic svc;
    logic resume;
    logic sys_rst;
    logic from_sleep;
  } ctl_state_t;
  ctl_state_t r;
  ctl_state_t next_r;

  // timer handshake
  logic tmr_load;
  logic [`TMR_W-1:0] tmr_value;
  logic tmr_done;

  // ==========================
  // helper functions
  // crystal family needs the start-up timer
  function automatic logic is_crystal(input logic [2:0] o);
    is_crystal = (o == `OSC_XT) || (o == `OSC_XT_PLL) || (o == `OSC_LP);
  endfunction
  // oscillator chosen for restart
  function automatic logic [2:0] pick_osc(input logic por, input logic sw,
                                          input logic [2:0] cur, input logic [2:0] cfg,
                                          input logic [1:0] src);
    if (por) begin
      pick_osc = (src == `OSC_SRC_FRC) ? `OSC_FRC : cfg;
    end else if (sw) begin
      pick_osc = cur;
    end else begin
      pick_osc = cfg;
    end
  endfunction

  pwr_pkg::wake_src_t wk;
  logic any_wake;
  logic short_dly;
  logic clk_ok;
  always_comb begin
    wk = '{irq: irq_wake_i, por: por_i, master_clear_pin: master_clear_pin_i, wdt: watchdog_timeout_i};
    any_wake = wk.irq || wk.por || wk.master_clear_pin || (wk.wdt && watchdog_enable_i);
    // clock usable: oscillator running, crystal start-up timer and, with pll, lock
    clk_ok = osc_running_i && (!is_crystal(r.osc) || osc_startup_done_i) &&
             ((r.osc != `OSC_XT_PLL) || pll_lock_i);
  end

  // ==========================
  // next-state logic
  always_comb begin
    next_r = r;
    tmr_load = 1'b0;
    tmr_value = `TMR_W'(`POR_DELAY_CYC);
    short_dly = 1'b0;
    next_r.svc = 1'b0;
    next_r.resume = 1'b0;
    next_r.sys_rst = 1'b0;
    next_r.trap = 1'b0;
    if (status_clear_i) begin
      next_r.stat = '0;
    end
    // watchdog timeout in run mode resets the device
    if (r.st == pwr_pkg::ST_RUN && watchdog_enable_i && wk.wdt) begin
      next_r.sys_rst = 1'b1;
      next_r.stat.watchdog_timeout_flag = 1'b1;
    end
    unique case (r.st)
      pwr_pkg::ST_RUN: begin
        next_r.clk = '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1,
                       low_power_rc_oscillator_en: watchdog_enable_i, fail_safe_clock_monitor_active: fail_safe_clock_monitor_enable_i};
        if (power_save_instruction_i) begin
          next_r.frc_force = 1'b0;
          next_r.osc = clk_switch_enable_i ? current_osc_select_i : osc_config_field_i;
          if (psave_operand_i == `PSAVE_OP_SLEEP) begin
            next_r.st = pwr_pkg::ST_SLEEP;
            // cpu and peripheral clocks stop; osc kept only for lp with lp_run_in_sleep_i; low_power_rc_oscillator only for the watchdog
            next_r.clk = '{cpu_clk_en: 1'b0, periph_clk_en: 1'b0,
                           osc_en: lp_run_in_sleep_i && current_osc_select_i == `OSC_LP,
                           low_power_rc_oscillator_en: watchdog_enable_i, fail_safe_clock_monitor_active: 1'b0};
          end else begin
            next_r.st = pwr_pkg::ST_IDLE;
            next_r.clk = '{cpu_clk_en: 1'b0, periph_clk_en: 1'b1, osc_en: 1'b1,
                           low_power_rc_oscillator_en: watchdog_enable_i || fail_safe_clock_monitor_enable_i,
                           fail_safe_clock_monitor_active: fail_safe_clock_monitor_enable_i};
          end
        end
      end
      pwr_pkg::ST_IDLE: begin
        if (any_wake) begin
          next_r.st = pwr_pkg::ST_RUN;
          next_r.clk.cpu_clk_en = 1'b1;
          next_r.resume = !wk.irq;
          next_r.svc = wk.irq;
          if (wk.por) begin
            next_r.stat = '0;
          end else begin
            next_r.stat.idle_flag = 1'b1;
            if (wk.wdt && watchdog_enable_i) begin
              next_r.stat.watchdog_timeout_flag = 1'b1;
            end
          end
          next_r.sys_rst = wk.por || wk.master_clear_pin;
        end
      end
      pwr_pkg::ST_SLEEP: begin
        if (any_wake) begin
          next_r.osc = pick_osc(wk.por, clk_switch_enable_i, r.osc,
                                osc_config_field_i, osc_source_config_i);
          // short path: external, fast rc, or lp kept alive in sleep
          short_dly = (next_r.osc == `OSC_EC) || (next_r.osc == `OSC_FRC) ||
                      ((next_r.osc == `OSC_LP) && lp_run_in_sleep_i);
          next_r.irq_pend = wk.irq && !wk.por && !wk.master_clear_pin;
          next_r.sys_rst = wk.por || wk.master_clear_pin;
          next_r.from_sleep = 1'b1;
          if (wk.por) begin
            next_r.stat = '0;
          end else begin
            next_r.stat.sleep_flag = 1'b1;
            if (wk.wdt && watchdog_enable_i) begin
              next_r.stat.watchdog_timeout_flag = 1'b1;
            end
          end
          next_r.clk.osc_en = 1'b1;
          next_r.st = pwr_pkg::ST_WAKE_DLY;
          tmr_load = 1'b1;
          if (short_dly) begin
            tmr_value = `TMR_W'(`POR_DELAY_CYC);
          end else begin
            // power-on, lock and power-up delays together
            tmr_value = `TMR_W'(`POR_DELAY_CYC) + (power_up_timer_enable_i ? POWER_UP_TIMER_CYC : '0) +
                        ((next_r.osc == `OSC_XT_PLL) ? LOCK_CYC : '0);
          end
        end
      end
      pwr_pkg::ST_WAKE_DLY: begin
        if (tmr_done) begin
          next_r.st = pwr_pkg::ST_WAIT_CLK;
        end
      end
      pwr_pkg::ST_WAIT_CLK: begin
        if (clk_ok) begin
          next_r.st = pwr_pkg::ST_WAKE_DONE;
        end else if (fail_safe_clock_monitor_enable_i) begin
          next_r.trap = 1'b1;
          next_r.frc_force = 1'b1;
          next_r.osc = `OSC_FRC;
          next_r.st = pwr_pkg::ST_WAKE_DONE;
        end
        // otherwise stall here until the clock is stable
      end
      pwr_pkg::ST_WAKE_DONE: begin
        next_r.clk = '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1,
                       low_power_rc_oscillator_en: watchdog_enable_i, fail_safe_clock_monitor_active: fail_safe_clock_monitor_enable_i};
        next_r.svc = r.irq_pend;
        next_r.resume = !r.irq_pend;
        next_r.irq_pend = 1'b0;
        next_r.from_sleep = 1'b0;
        next_r.st = pwr_pkg::ST_RUN;
      end
      default: begin
        next_r.st = pwr_pkg::ST_RUN;
      end
    endcase
  end

  // ==========================
  // state register
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: pwr_pkg::ST_RUN, stat: '0,
             clk: '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1,
                    low_power_rc_oscillator_en: 1'b0, fail_safe_clock_monitor_active: 1'b0},
             osc: `OSC_FRC, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ==========================
  // wake delay timer
  pwr_wake_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .load_i(tmr_load),
    .value_i(tmr_value),
    .done_o(tmr_done)
  );

  // ==========================
  // outputs
  assign cpu_clk_en_o = r.clk.cpu_clk_en;
  // per-module idle stop bits gate peripherals
  assign periph_clk_en_o = {8{r.clk.periph_clk_en}} &
                           ~((r.st == pwr_pkg::ST_IDLE) ? periph_idle_stop_i : 8'h00);
  assign osc_en_o = r.clk.osc_en;
  assign low_power_rc_oscillator_en_o = r.clk.low_power_rc_oscillator_en;
  assign fail_safe_clock_monitor_active_o = r.clk.fail_safe_clock_monitor_active;
  assign wake_osc_o = r.osc;
  assign clock_fail_trap_o = r.trap;
  assign fast_rc_force_o = r.frc_force;
  assign service_irq_o = r.svc;
  assign resume_next_o = r.resume;
  assign system_reset_o = r.sys_rst;
  assign sleep_flag_o = r.stat.sleep_flag;
  assign idle_flag_o = r.stat.idle_flag;
  assign watchdog_timeout_flag_o = r.stat.watchdog_timeout_flag;

  // ==========================
  // checks
  sleep_clk_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    r.st == pwr_pkg::ST_SLEEP |-> !cpu_clk_en_o && periph_clk_en_o == 8'h00)
    else $error("clocks running in sleep");
  idle_cpu_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    r.st == pwr_pkg::ST_IDLE |-> !cpu_clk_en_o && osc_en_o)
    else $error("idle clock gating wrong");
  sleep_fail_safe_clock_monitor_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    r.st == pwr_pkg::ST_SLEEP |-> !fail_safe_clock_monitor_active_o)
    else $error("monitor active in sleep");
  idle_wake_fast_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    r.st == pwr_pkg::ST_IDLE && irq_wake_i |=> cpu_clk_en_o && service_irq_o)
    else $error("idle wake not immediate");
  sleep_wdt_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    r.st == pwr_pkg::ST_SLEEP && watchdog_timeout_i && watchdog_enable_i && !por_i && !master_clear_pin_i
    |=> sleep_flag_o && watchdog_timeout_flag_o && !system_reset_o)
    else $error("watchdog sleep wake flags wrong");
  por_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (r.st == pwr_pkg::ST_SLEEP || r.st == pwr_pkg::ST_IDLE) && por_i
    |=> !sleep_flag_o && !idle_flag_o)
    else $error("power-on wake did not clear flags");
  wake_stall_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    r.st == pwr_pkg::ST_WAIT_CLK && !clk_ok && !fail_safe_clock_monitor_enable_i |=> !cpu_clk_en_o)
    else $error("ran without stable clock");
  idle_flag_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    r.st == pwr_pkg::ST_IDLE && irq_wake_i && !por_i && !status_clear_i |=> idle_flag_o)
    else $error("idle flag not set");
endmodule

// *** sleep_idle_power_controller_tb.sv ***
// self-checking testbench for the sleep and idle power controller
`timescale 1ns/1ps
`include "pwr_defines.svh"
module sleep_idle_power_controller_tb;
  // ==========
  // stimulus and observed signals
  logic sys_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic psi = 1'h0; // power-save pulse
  logic op = 1'h0; // operand
  logic [3:0] wk = 4'h0; // wake: irq, por, master_clear_pin, watchdog
  logic wdt_en = 1'h1;
  logic fail_safe_clock_monitor = 1'h1;
  logic csw = 1'h1;
  logic power_up_timer = 1'h1;
  logic [2:0] sel = 3'h0;
  logic [2:0] cfg = 3'h0;
  logic [1:0] src = 2'h1;
  logic lprun = 1'h1;
  logic oscillator_startup_timer = 1'h1;
  logic lock = 1'h1;
  logic run = 1'h1;
  logic [7:0] stop = 8'h0F;
  logic clr = 1'h0;
  logic cpu_en, osc_en, low_power_rc_oscillator_en, fail_safe_clock_monitor_act, trap, frc_force, svc, resume, sysrst;
  logic sflag, iflag, wflag;
  logic [7:0] per_en;
  logic [2:0] wosc;
  int mismatches = 0;
  int tests_run = 0;
  int n;
  // ==========
  // clock and design, long timers shortened
  always #2 sys_clk_i = ~sys_clk_i;
  pwr_ctrl #(.POWER_UP_TIMER_CYC(20'h00032), .LOCK_CYC(20'h0000A)) uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .power_save_instruction_i(psi),
    .psave_operand_i(op), .irq_wake_i(wk[0]), .por_i(wk[1]), .master_clear_pin_i(wk[2]),
    .watchdog_timeout_i(wk[3]), .watchdog_enable_i(wdt_en), .fail_safe_clock_monitor_enable_i(fail_safe_clock_monitor),
    .clk_switch_enable_i(csw), .power_up_timer_enable_i(power_up_timer), .current_osc_select_i(sel),
    .osc_config_field_i(cfg), .osc_source_config_i(src), .lp_run_in_sleep_i(lprun),
    .osc_startup_done_i(oscillator_startup_timer), .pll_lock_i(lock), .osc_running_i(run),
    .periph_idle_stop_i(stop), .status_clear_i(clr), .cpu_clk_en_o(cpu_en),
    .periph_clk_en_o(per_en), .osc_en_o(osc_en), .low_power_rc_oscillator_en_o(low_power_rc_oscillator_en),
    .fail_safe_clock_monitor_active_o(fail_safe_clock_monitor_act), .wake_osc_o(wosc),
    .clock_fail_trap_o(trap), .fast_rc_force_o(frc_force), .service_irq_o(svc),
    .resume_next_o(resume), .system_reset_o(sysrst), .sleep_flag_o(sflag),
    .idle_flag_o(iflag), .watchdog_timeout_flag_o(wflag));
  // ==========
  // shared helpers
  // compare and count
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // wait k falling edges, where outputs are settled
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  // one-cycle power-save pulse with its operand
  task automatic psave(input logic o);
    @(posedge sys_clk_i);
    psi <= 1'h1;
    op <= o;
    @(posedge sys_clk_i);
    psi <= 1'h0;
    cyc(3);
  endtask
  // one-cycle wake event
  task automatic kick(input logic [3:0] v);
    @(posedge sys_clk_i);
    wk <= v;
    @(posedge sys_clk_i);
    wk <= 4'h0;
  endtask
  // bounded wait for any result pulse
  task automatic wait_ev(input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim && svc !== 1'h1 && resume !== 1'h1 && sysrst !== 1'h1 && trap !== 1'h1) begin
      @(negedge sys_clk_i);
      cnt++;
    end
  endtask
  // clear the status flags
  task automatic flags_clear();
    @(posedge sys_clk_i);
    clr <= 1'h1;
    @(posedge sys_clk_i);
    clr <= 1'h0;
    cyc(1);
  endtask
  // ==========
  // scenarios
  // levels straight after reset
  task automatic t_reset();
    chk("cpu_en", 16'h1, cpu_en);
    chk("per_en", 16'hFF, per_en);
    chk("flags", 16'h0, {sflag, iflag, wflag});
    $display("test reset finished");
  endtask
  // idle entry, refused second pulse, interrupt wake
  task automatic t_idle_irq();
    flags_clear();
    psave(1'h1);
    chk("idle cpu_en", 16'h0, cpu_en);
    chk("idle osc_en", 16'h1, osc_en);
    chk("idle per_en", 16'hF0, per_en);
    chk("idle low_power_rc_oscillator_en", 16'h1, low_power_rc_oscillator_en);
    psave(1'h0);
    chk("refused osc_en", 16'h1, osc_en);
    kick(4'h1);
    wait_ev(4, n);
    chk("idle svc", 16'h1, svc);
    chk("idle cpu back", 16'h1, cpu_en);
    chk("idle no delay", 16'h1, 16'(n < 3));
    chk("idle flag", 16'h1, iflag);
    $display("test idle irq finished");
  endtask
  // run watchdog reset, idle watchdog wake, then resets from idle
  task automatic t_idle_other();
    kick(4'h8);
    wait_ev(4, n);
    chk("run wdt reset", 16'h3, {sysrst, wflag});
    flags_clear();
    psave(1'h1);
    kick(4'h8);
    wait_ev(4, n);
    chk("wdt resume", 16'h1, resume);
    chk("wdt flags", 16'h3, {iflag, wflag});
    flags_clear();
    psave(1'h1);
    kick(4'h4);
    wait_ev(4, n);
    chk("master_clear_pin reset", 16'h1, sysrst);
    chk("master_clear_pin idle flag", 16'h1, iflag);
    psave(1'h1);
    kick(4'h2);
    wait_ev(4, n);
    chk("por idle flag", 16'h0, iflag);
    $display("test idle other finished");
  endtask
  // sleep entry and wake timing for one oscillator
  task automatic t_sleep(input logic [2:0] cur, input logic [3:0] v, input int lo, input int hi);
    flags_clear();
    @(posedge sys_clk_i);
    sel <= cur;
    psave(1'h0);
    chk("sleep enables", 16'(cur == `OSC_LP), {cpu_en, per_en, osc_en});
    chk("sleep monitor", 16'h0, fail_safe_clock_monitor_act);
    chk("sleep low_power_rc_oscillator", 16'h1, low_power_rc_oscillator_en);
    kick(v);
    wait_ev(4000, n);
    chk("wake kind", {15'h0, v[0]}, svc);
    chk("wake resume", {15'h0, v[3]}, resume);
    chk("wake delay", 16'h1, 16'((n >= lo) && (n <= hi)));
    chk("wake osc", {13'h0, cur}, wosc);
    chk("wake flags", {14'h1, v[3]}, {sflag, wflag});
    cyc(2);
    chk("wake enables", 16'h1, cpu_en);
    $display("test sleep %0h finished", cur);
  endtask
  // power-on wake picks oscillator from configuration
  task automatic t_sleep_por();
    @(posedge sys_clk_i);
    sel <= `OSC_FRC;
    cfg <= `OSC_EC;
    psave(1'h0);
    kick(4'h2);
    wait_ev(4000, n);
    cyc(3);
    chk("por osc", {13'h0, `OSC_EC}, wosc);
    chk("por sleep flag", 16'h0, sflag);
    wait_ev(4000, n);
    chk("por wake done", 16'h1, resume);
    cyc(2);
    $display("test sleep por finished");
  endtask
  // dead crystal: stall without monitor, trap with it
  task automatic t_clk_dead(input logic f);
    @(posedge sys_clk_i);
    fail_safe_clock_monitor <= f;
    run <= 1'h0;
    sel <= `OSC_XT;
    psave(1'h0);
    kick(4'h1);
    wait_ev(3200, n);
    if (f) begin
      chk("trap", 16'h1, trap);
      cyc(1);
      chk("frc force", 16'h1, frc_force);
      psave(1'h1);
      chk("frc cleared", 16'h0, frc_force);
      kick(4'h1);
    end else begin
      chk("stalled", 16'h0, svc);
      @(posedge sys_clk_i);
      run <= 1'h1;
      wait_ev(20, n);
      chk("late svc", 16'h1, svc);
    end
    @(posedge sys_clk_i);
    run <= 1'h1;
    cyc(10);
    $display("test clock dead %0h finished", f);
  endtask
  // ==========
  // verdict
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard, well above the expected run
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    mismatches++;
    $display("BAD watchdog expected finish seen hang");
    complete_run();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    cyc(4);
    t_reset();
    t_idle_irq();
    t_idle_other();
    t_sleep(`OSC_FRC, 4'h1, 2495, 2540);
    t_sleep(`OSC_XT_PLL, 4'h8, 2555, 2650);
    t_sleep(`OSC_LP, 4'h1, 2495, 2540);
    t_sleep_por();
    t_clk_dead(1'h0);
    t_clk_dead(1'h1);
    complete_run();
  end
endmodule
